// ### lso_unit.sv
// Load/store ordering unit between instruction issue and the data cache.
`default_nettype none

module lso_unit
  import lso_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    big_endian_select,
  input  wire logic                    prefetch_enable,
  input  wire logic                    iss_valid,
  output logic                         iss_ready,
  input  wire lso_op_type              iss_op,
  input  wire lso_size_type            iss_size,
  input  wire logic [ADDR_W-1:0]       iss_addr,
  input  wire logic [FP_W-1:0]         iss_sdata,
  input  wire logic [REG_W-1:0]        iss_dest,
  input  wire logic                    iss_stop,
  output logic                         misalign_fault,
  output logic                         ld_valid,
  output logic      [REG_W-1:0]        ld_dest,
  output logic      [DATA_W-1:0]       ld_data,
  input  wire logic                    cons_valid,
  input  wire logic [REG_W-1:0]        cons_src_a,
  input  wire logic [REG_W-1:0]        cons_src_b,
  output logic                         cons_stall,
  output logic      [GROUP_W-1:0]      group_id,
  output logic                         mem_req,
  output logic                         mem_we,
  output logic                         mem_prefetch,
  output logic      [LINE_W-1:0]       mem_line,
  output logic      [LINE_BYTES*8-1:0] mem_wdata,
  output logic      [LINE_BYTES-1:0]   mem_wstrb,
  input  wire logic                    mem_ready,
  input  wire logic [LINE_BYTES*8-1:0] mem_rdata
);

  lso_state_type st;
  lso_state_type next_st;

  logic [OFF_W-1:0]  iss_off;
  logic [4:0]        iss_bytes;
  logic              bad_access;
  logic              is_load;
  logic              is_store;
  logic              is_hint;
  logic              needs_mem;
  logic              iss_take;
  logic              load_take;
  logic [DATA_W-1:0] load_data;

  assign iss_off   = iss_addr[OFF_W-1:0];
  assign iss_bytes = lso_size_bytes(iss_size);
  assign is_load   = (iss_op == OP_LOAD);
  assign is_store  = (iss_op == OP_STORE);
  // The hint is dropped when prefetching is disabled; it never returns data or writes.
  assign is_hint   = (iss_op == OP_PREFETCH) && prefetch_enable;

  // An access may not cross a line, and the ten-byte width exists for stores only.
  assign bad_access = (is_load || is_store) &&
                      (({1'b0, iss_off} + iss_bytes > 5'(LINE_BYTES)) ||
                       (is_load && (iss_size == SZ10)));

  assign needs_mem = (is_load || is_store || is_hint) && !bad_access;
  // One access per cycle in program order keeps every memory dependency in a group sequential.
  assign iss_ready = !needs_mem || mem_ready;
  assign iss_take  = iss_valid && iss_ready;
  assign load_take = iss_take && is_load && !bad_access;

  assign mem_req      = iss_valid && needs_mem;
  assign mem_we       = is_store;
  assign mem_prefetch = is_hint;
  assign mem_line     = iss_addr[ADDR_W-1:OFF_W];

  lso_store_pack u_store_pack (
    .sdata (iss_sdata),
    .size  (iss_size),
    .off   (iss_off),
    .big   (big_endian_select),
    .wdata (mem_wdata),
    .wstrb (mem_wstrb)
  );

  lso_load_unpack u_load_unpack (
    .rdata (mem_rdata),
    .size  (st.s1_size),
    .off   (st.s1_off),
    .big   (st.s1_big),
    .data  (load_data)
  );

  // A result is still in flight while its load is being taken or in the cycle after, while its line is unpacked.
  always_comb begin
    cons_stall = 1'b0;
    if (cons_valid) begin
      if (st.s1_valid && ((cons_src_a == st.s1_dest) || (cons_src_b == st.s1_dest))) begin
        cons_stall = 1'b1;
      end
      if (load_take && ((cons_src_a == iss_dest) || (cons_src_b == iss_dest))) begin
        cons_stall = 1'b1;
      end
    end
  end

  always_comb begin
    next_st = st;
    next_st.fault = iss_take && bad_access;
    next_st.s1_valid = load_take;
    if (load_take) begin
      next_st.s1_dest = iss_dest;
      next_st.s1_off  = iss_off;
      next_st.s1_size = iss_size;
      // Byte order is latched at issue so a change of the select bit cannot split a load.
      next_st.s1_big  = big_endian_select;
    end
    next_st.s2_valid = st.s1_valid;
    if (st.s1_valid) begin
      next_st.s2_dest = st.s1_dest;
      next_st.s2_data = load_data;
      next_st.s2_size = st.s1_size;
    end
    if (iss_take && iss_stop) begin
      next_st.group_id = st.group_id + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign misalign_fault = st.fault;
  assign ld_valid       = st.s2_valid;
  assign ld_dest        = st.s2_dest;
  assign ld_data        = st.s2_data;
  assign group_id       = st.group_id;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_load_latency_two: assert property (
    load_take |-> ##2 (ld_valid && (ld_dest == $past(iss_dest, 2)))
  ) else $error("load result not delivered two cycles after issue");

  a_load_no_early: assert property (
    ld_valid |-> $past(load_take, 2)
  ) else $error("load result appeared without a load two cycles earlier");

  a_zero_extend: assert property (
    (ld_valid && (st.s2_size == SZ4)) |-> (ld_data[63:32] == 32'h0000_0000)
  ) else $error("four byte load not zero extended");

  a_byte_zero_ext: assert property (
    (ld_valid && (st.s2_size == SZ1)) |-> (ld_data[63:8] == 56'h0)
  ) else $error("one byte load not zero extended");

  a_consumer_stall: assert property (
    (load_take ##1 (cons_valid && (cons_src_a == $past(iss_dest)))) |-> cons_stall
  ) else $error("consumer read a load result too early");

  a_stall_cause: assert property (
    cons_stall |-> (load_take || st.s1_valid)
  ) else $error("stall without a pending load");

  a_store_strobes: assert property (
    (iss_take && is_store && !bad_access) |-> (mem_req && mem_we &&
      ($countones(mem_wstrb) == int'(iss_bytes)))
  ) else $error("store byte count differs from its width");

  a_store_low_bytes: assert property (
    (mem_req && mem_we && (iss_size == SZ4) && (iss_off == 4'h0) && !big_endian_select) |->
      ((mem_wdata[31:0] == iss_sdata[31:0]) && (mem_wstrb == 16'h000f))
  ) else $error("four byte store not taken from low register bytes");

  a_store_big_order: assert property (
    (mem_req && mem_we && (iss_size == SZ8) && (iss_off == 4'h0) && big_endian_select) |->
      (mem_wdata[63:0] == 64'({<<8{iss_sdata[63:0]}}))
  ) else $error("big-endian store byte order wrong");

  a_hint_no_write: assert property (
    mem_prefetch |-> (!mem_we && !load_take)
  ) else $error("prefetch hint changed visible state");

  a_fault_no_access: assert property (
    (iss_valid && bad_access) |-> (!mem_req ##1 misalign_fault)
  ) else $error("bad access reached memory or was not flagged");

  a_group_advance: assert property (
    (iss_take && iss_stop) |=> (group_id == $past(group_id) + 16'h0001)
  ) else $error("stop did not end the instruction group");

endmodule

`default_nettype wire

// ### lso_pkg.sv
// Constants, types and shared byte-ordering functions for the load/store ordering unit.
// Notes on behaviour
// - Stores write 1,2,4,8 bytes; float 4,8,10.
// - Narrow store uses register's least significant bytes.
// - Little-endian default; select bit gives big-endian.
// - Integer loads read 1, 2, 4 or 8 bytes.
// - Narrow load data zero-extended to 64 bits.
// - Prefetch hint may be ignored, never changes results.
// - Memory dependencies inside a group honoured sequentially.
// - Same-address stores: later store's value remains.
// - Load after overlapping store sees store's bytes.
// - Stop ends group; next group reads results.
// - Load data delivered two cycles after issue.
// - Early consumer of load result stalls.
`default_nettype none

package lso_pkg;

  localparam int unsigned LINE_BYTES       = 16;
  localparam int unsigned OFF_W            = 4;
  localparam int unsigned LINE_W           = 60;
  localparam int unsigned ADDR_W           = 64;
  localparam int unsigned DATA_W           = 64;
  localparam int unsigned FP_W             = 80;
  localparam int unsigned REG_W            = 7;
  localparam int unsigned GROUP_W          = 16;
  localparam int unsigned LOAD_LATENCY_CYC = 2;

  typedef enum logic [3:0] {
    OP_NOP      = 4'h1,
    OP_LOAD     = 4'h2,
    OP_STORE    = 4'h4,
    OP_PREFETCH = 4'h8
  } lso_op_type;

  typedef enum logic [2:0] {
    SZ1  = 3'h0,
    SZ2  = 3'h1,
    SZ4  = 3'h2,
    SZ8  = 3'h3,
    SZ10 = 3'h4
  } lso_size_type;

  typedef struct packed {
    logic                  s1_valid;
    logic [REG_W-1:0]      s1_dest;
    logic [OFF_W-1:0]      s1_off;
    lso_size_type          s1_size;
    logic                  s1_big;
    logic                  s2_valid;
    logic [REG_W-1:0]      s2_dest;
    logic [DATA_W-1:0]     s2_data;
    lso_size_type          s2_size;
    logic                  fault;
    logic [GROUP_W-1:0]    group_id;
  } lso_state_type;

  localparam lso_state_type STATE_RESET = '{default: '0, s1_size: SZ1, s2_size: SZ1};

  function automatic logic [4:0] lso_size_bytes(input lso_size_type s);
    case (s)
      SZ1:     return 5'h01;
      SZ2:     return 5'h02;
      SZ4:     return 5'h04;
      SZ8:     return 5'h08;
      SZ10:    return 5'h0a;
      default: return 5'h00;
    endcase
  endfunction

  // Keeps the low n bytes of v, optionally reversed; bytes above n read as zero.
  function automatic logic [FP_W-1:0] lso_order_bytes(input logic [FP_W-1:0] v, input logic [4:0] n,
                                                      input logic big);
    logic [FP_W-1:0] r;
    r = '0;
    for (int i = 0; i < 10; i++) begin
      for (int j = 0; j < 10; j++) begin
        if ((5'(i) < n) && (5'(j) == (big ? n - 5'h01 - 5'(i) : 5'(i)))) begin
          r[i*8 +: 8] = v[j*8 +: 8];
        end
      end
    end
    return r;
  endfunction

endpackage

`default_nettype wire

// ### lso_store_pack.sv
// Places store data onto the line-wide write bus with byte strobes.
`default_nettype none

module lso_store_pack
  import lso_pkg::*;
(
  input  wire logic [FP_W-1:0]         sdata,
  input  wire lso_size_type            size,
  input  wire logic [OFF_W-1:0]        off,
  input  wire logic                    big,
  output logic      [LINE_BYTES*8-1:0] wdata,
  output logic      [LINE_BYTES-1:0]   wstrb
);

  logic [FP_W-1:0] ordered;
  logic [4:0]      n;

  always_comb begin
    logic [4:0] idx;
    idx = '0;
    n = lso_size_bytes(size);
    ordered = lso_order_bytes(sdata, n, big);
    wdata = '0;
    wstrb = '0;
    for (int k = 0; k < LINE_BYTES; k++) begin
      idx = 5'(k) - {1'b0, off};
      if ((5'(k) >= {1'b0, off}) && (idx < n)) begin
        wdata[k*8 +: 8] = ordered[idx*8 +: 8];
        wstrb[k] = 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ### lso_load_unpack.sv
// Extracts load bytes from the returned line, orders them and zero-extends.
`default_nettype none

module lso_load_unpack
  import lso_pkg::*;
(
  input  wire logic [LINE_BYTES*8-1:0] rdata,
  input  wire lso_size_type            size,
  input  wire logic [OFF_W-1:0]        off,
  input  wire logic                    big,
  output logic      [DATA_W-1:0]       data
);

  logic [FP_W-1:0] raw;
  logic [FP_W-1:0] ordered;

  always_comb begin
    logic [4:0] lane;
    lane = '0;
    raw = '0;
    for (int j = 0; j < 8; j++) begin
      lane = {1'b0, off} + 5'(j);
      if (lane < 5'(LINE_BYTES)) begin
        raw[j*8 +: 8] = rdata[lane[3:0]*8 +: 8];
      end
    end
    // Bytes beyond the access width are dropped here, which gives the zero extension.
    ordered = lso_order_bytes(raw, lso_size_bytes(size), big);
    data = ordered[DATA_W-1:0];
  end

endmodule

`default_nettype wire

// ### lso_mem_model.sv
// Behavioural data cache that answers the load/store unit's line requests.
`default_nettype none

module lso_mem_model
  import lso_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    slow,
  input  wire logic                    mem_req,
  input  wire logic                    mem_we,
  input  wire logic                    mem_prefetch,
  input  wire logic [LINE_W-1:0]       mem_line,
  input  wire logic [LINE_BYTES*8-1:0] mem_wdata,
  input  wire logic [LINE_BYTES-1:0]   mem_wstrb,
  output logic                         mem_ready,
  output logic      [LINE_BYTES*8-1:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem [logic [63:0]];
  logic [63:0] a;

  initial begin
    mem_ready = 1'b1;
    mem_rdata = '0;
  end

  always @(posedge clk) begin
    mem_ready <= slow ? 1'($urandom) : 1'b1;
    // Read data only holds for one cycle; a late sample sees inverted bytes.
    mem_rdata <= ~mem_rdata;
    if (mem_req && mem_ready) begin
      for (int k = 0; k < LINE_BYTES; k++) begin
        a = {mem_line, 4'(k)};
        if (mem_we && mem_wstrb[k]) mem[a] = mem_wdata[k*8 +: 8];
        if (!mem_we && !mem_prefetch) mem_rdata[k*8 +: 8] <= mem.exists(a) ? mem[a] : a[7:0] ^ 8'h5a;
      end
    end
  end
endmodule

`default_nettype wire

// ### lso_unit_test.sv
// Self-checking testbench of the load/store ordering unit.
`default_nettype none

module lso_unit_test;
  import lso_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic                    clk = 1'b0;
  logic                    sys_rst = 1'b1;
  logic                    big_endian_select, prefetch_enable, iss_valid, iss_ready, iss_stop, misalign_fault;
  logic                    ld_valid, cons_valid, cons_stall, mem_req, mem_we, mem_prefetch, mem_ready, slow;
  lso_op_type              iss_op;
  lso_size_type            iss_size;
  logic [ADDR_W-1:0]       iss_addr;
  logic [FP_W-1:0]         iss_sdata;
  logic [REG_W-1:0]        iss_dest, ld_dest, cons_src_a, cons_src_b, prev_dest;
  logic [DATA_W-1:0]       ld_data;
  logic [GROUP_W-1:0]      group_id, n_stop;
  logic [LINE_W-1:0]       mem_line;
  logic [LINE_BYTES*8-1:0] mem_wdata, mem_rdata;
  logic [LINE_BYTES-1:0]   mem_wstrb;
  logic [7:0]              ref_mem [logic [63:0]];
  logic [102:0]            ld_q [$];
  logic                    prev_ld, prev_bad, flt_next;
  lso_op_type              ops [4] = '{OP_NOP, OP_LOAD, OP_STORE, OP_PREFETCH};
  int                      n_errors, comparisons, cyc;

  lso_unit dut (.clk, .sys_rst, .big_endian_select, .prefetch_enable, .iss_valid, .iss_ready, .iss_op, .iss_size,
    .iss_addr, .iss_sdata, .iss_dest, .iss_stop, .misalign_fault, .ld_valid, .ld_dest, .ld_data, .cons_valid,
    .cons_src_a, .cons_src_b, .cons_stall, .group_id, .mem_req, .mem_we, .mem_prefetch, .mem_line, .mem_wdata,
    .mem_wstrb, .mem_ready, .mem_rdata);
  lso_mem_model mem (.clk, .slow, .mem_req, .mem_we, .mem_prefetch, .mem_line, .mem_wdata, .mem_wstrb,
    .mem_ready, .mem_rdata);

  always #50 clk = ~clk;

  task automatic check(string what, logic [71:0] exp, logic [71:0] got);
    comparisons++;
    if (exp !== got) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] rd(logic [63:0] a);
    return ref_mem.exists(a) ? ref_mem[a] : a[7:0] ^ 8'h5a;
  endfunction

  // Drives one instruction and notes what it must produce once it is taken.
  task automatic issue(lso_op_type op, lso_size_type sz, logic [63:0] addr, logic big, logic stop);
    int n;
    logic ok, bad, tk, rdy;
    logic [63:0] v;
    logic [6:0] d;
    n = (sz == SZ10) ? 10 : 1 << int'(sz);
    ok = (int'(addr[3:0]) + n <= 16) && !(op == OP_LOAD && sz == SZ10);
    bad = !ok && (op == OP_LOAD || op == OP_STORE);
    d = 7'($urandom_range(1, 6));
    @(negedge clk);
    iss_valid = 1'b1;
    iss_op = op;
    iss_size = sz;
    iss_addr = addr;
    iss_sdata = {16'($urandom), $urandom, $urandom};
    iss_dest = d;
    iss_stop = stop;
    big_endian_select = big;
    prefetch_enable = 1'($urandom);
    cons_src_a = prev_dest;
    cons_src_b = d;
    cons_valid = 1'($urandom) && !bad && !prev_bad;
    rdy = 1'b0;
    for (int t = 0; t < 60; t++) begin
      // Outputs are sampled shortly before the edge, where they have settled.
      #40;
      rdy = iss_ready;
      tk = rdy && op == OP_LOAD && ok;
      check("cons_stall", cons_valid && (prev_ld && (cons_src_a == prev_dest || cons_src_b == prev_dest)
        || tk && (cons_src_a == d || cons_src_b == d)), cons_stall);
      flt_next = rdy && bad;
      prev_ld = tk;
      prev_dest = d;
      @(posedge clk);
      if (rdy) break;
      @(negedge clk);
    end
    if (!rdy) begin
      n_errors++;
      finish_test;
    end
    prev_bad = bad;
    if (stop) n_stop++;
    v = '0;
    if (op == OP_LOAD && ok) begin
      for (int k = 0; k < n; k++) v[k*8 +: 8] = rd(addr + 64'(big ? n - 1 - k : k));
      ld_q.push_back({32'(cyc + 1), d, v});
    end
    if (op == OP_STORE && ok) begin
      for (int k = 0; k < n; k++) ref_mem[addr + 64'(big ? n - 1 - k : k)] = iss_sdata[k*8 +: 8];
    end
  endtask

  always @(negedge clk) begin
    logic [102:0] e;
    if (!sys_rst) begin
      check("misalign_fault", 72'(flt_next), 72'(misalign_fault));
      check("group_id", 72'(n_stop), 72'(group_id));
      if (ld_q.size() > 0 && ld_q[0][102:71] == 32'(cyc)) begin
        e = ld_q.pop_front();
        check("load result", {1'b1, e[70:0]}, {ld_valid, ld_dest, ld_data});
      end else begin
        check("ld_valid", 72'h0, 72'(ld_valid));
      end
      cyc++;
    end
  end

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #(100 * 8000);
    n_errors++;
    finish_test;
  end

  initial begin
    lso_op_type o;
    {iss_valid, iss_stop, cons_valid, big_endian_select, prefetch_enable, slow} = '0;
    {prev_ld, prev_bad, flt_next, n_stop, prev_dest, cyc} = '0;
    iss_op = OP_NOP;
    iss_size = SZ1;
    {iss_addr, iss_sdata, iss_dest, cons_src_a, cons_src_b} = '0;
    void'($urandom(32'ha3e58bcc));
    repeat (16) @(posedge clk);
    @(negedge clk);
    sys_rst <= 1'b0;
    // Same-address stores in one group, then an overlapping load, in both byte orders.
    for (int b = 0; b < 2; b++) begin
      for (int s = 0; s < 5; s++) begin
        issue(OP_STORE, lso_size_type'(s), 64'(48 + s), 1'(b), 1'b0);
        issue(OP_STORE, lso_size_type'(s), 64'(48 + s), 1'(b), 1'b0);
        issue(OP_LOAD, s == 4 ? SZ8 : lso_size_type'(s), 64'(48 + s), 1'(b), 1'b1);
      end
    end
    $display("test ordering done");
    // Dropping the request here keeps the last instruction from being taken a second time.
    @(negedge clk);
    iss_valid = 1'b0;
    prev_ld = 1'b0;
    slow = 1'b1;
    for (int i = 0; i < 400; i++) begin
      o = ops[$urandom_range(0, 3)];
      issue(o, o == OP_PREFETCH ? SZ1 : lso_size_type'($urandom_range(0, 4)), 64'($urandom_range(0, 63)),
        1'($urandom), 1'($urandom));
    end
    repeat (4) issue(OP_NOP, SZ1, 64'h0, 1'b0, 1'b0);
    check("pending loads", 72'h0, 72'(ld_q.size()));
    $display("test random mix done");
    finish_test;
  end
endmodule

`default_nettype wire
